// [src/tcf_core.sv]
// touch coordinate filtering, reporting modes and standby control
`timescale 1ns/1ps
`include "tcf_consts.svh"
module tcf_core (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_brownout,
  input wire logic i_touch,
  input wire logic i_sample_valid,
  input wire tcf_pkg::tcf_coord_type i_sample,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_standby_force_n,
  input wire logic i_cfg_we,
  input wire logic [7:0] i_cfg_samples,
  input wire logic [5:0] i_cfg_delta,
  input wire logic [5:0] i_cfg_focus,
  input wire logic [7:0] i_cfg_mode,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output tcf_pkg::tcf_coord_type o_tx_coord,
  output logic o_reply_valid,
  output logic [7:0] o_reply_byte,
  output logic o_uart_flush,
  output logic o_standby,
  output logic o_activity_indicator,
  output logic o_self_pd_en
);
  logic rst;
  tcf_pkg::tcf_pwr_type pwr;
  tcf_pkg::tcf_pwr_type next_pwr;
  logic run;
  logic [15:0] idle_cnt;
  logic force_q;
  logic [7:0] samples;
  logic [5:0] delta_lim;
  logic [5:0] focus_lim;
  logic [7:0] mode;
  logic [5:0] acc_n;
  logic [14:0] acc [3];
  logic [9:0] avg [3];
  logic avg_valid;
  logic [9:0] hist1 [2];
  logic [9:0] hist2 [2];
  logic [1:0] hist_cnt;
  logic [9:0] focus_st [2];
  logic accept;
  logic [9:0] filt [2];
  logic [9:0] filt_z;
  logic filt_valid;
  logic touch_q;
  logic first_sent;
  tcf_pkg::tcf_coord_type last_coord;
  logic have_last;
  logic fifo_in_valid;
  logic fifo_in_ready;
  tcf_pkg::tcf_coord_type fifo_in_data;
  logic fifo_out_valid;
  tcf_pkg::tcf_coord_type fifo_out_data;
  logic rx_shutdown;
  logic rx_wakeup;
  logic [2:0] log2_s;

  assign rst = i_reset || i_brownout;
  assign run = (pwr == tcf_pkg::TCF_RUN) && i_standby_force_n;
  assign rx_shutdown = i_rx_valid && i_rx_byte == `TCF_CMD_SHUTDOWN;
  assign rx_wakeup = i_rx_valid && i_rx_byte == `TCF_CMD_WAKEUP;

  // power state choice; force pin overrides everything except reset
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      tcf_pkg::TCF_RUN: begin
        if (rx_shutdown) next_pwr = tcf_pkg::TCF_SLEEP_CMD;
        else if (o_self_pd_en && idle_cnt == `TCF_IDLE_TIMEOUT_CYCLES)
          next_pwr = tcf_pkg::TCF_SLEEP_SELF;
      end
      tcf_pkg::TCF_SLEEP_SELF: begin
        if (i_touch || i_rx_valid) next_pwr = tcf_pkg::TCF_RUN;
      end
      tcf_pkg::TCF_SLEEP_CMD: begin
        if (rx_wakeup || (o_self_pd_en && i_touch)) next_pwr = tcf_pkg::TCF_RUN;
      end
    endcase
  end

  // power state register; held while the force pin is low
  always_ff @(posedge i_clk_sys) begin
    if (rst) pwr <= tcf_pkg::TCF_RUN;
    else if (i_standby_force_n) pwr <= next_pwr;
  end

  // idle counter for self power down
  always_ff @(posedge i_clk_sys) begin
    if (rst || !run || i_touch || i_rx_valid) idle_cnt <= '0;
    else if (idle_cnt != `TCF_IDLE_TIMEOUT_CYCLES) idle_cnt <= idle_cnt + 16'h0001;
  end

  // standby outputs and uart flush on wake from command sleep or on force pin release
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      force_q <= 1'b1;
      o_standby <= 1'b0;
      o_activity_indicator <= 1'b0;
      o_uart_flush <= 1'b0;
    end else begin
      force_q <= i_standby_force_n;
      o_standby <= !(next_pwr == tcf_pkg::TCF_RUN && i_standby_force_n);
      o_activity_indicator <= !(next_pwr == tcf_pkg::TCF_RUN && i_standby_force_n);
      o_uart_flush <= (i_standby_force_n && !force_q)
        || (pwr == tcf_pkg::TCF_SLEEP_CMD && next_pwr == tcf_pkg::TCF_RUN && i_standby_force_n);
    end
  end

  // configuration and toggle command; wakeup never answers
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      samples <= `TCF_SAMPLES_DEFAULT;
      delta_lim <= `TCF_DELTA_DEFAULT;
      focus_lim <= `TCF_FOCUS_DEFAULT;
      mode <= `TCF_MODE_STREAM;
      o_self_pd_en <= `TCF_SPD_DEFAULT;
      o_reply_valid <= 1'b0;
      o_reply_byte <= 8'h00;
    end else begin
      o_reply_valid <= 1'b0;
      if (i_cfg_we && run) begin
        if (i_cfg_samples inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20}) samples <= i_cfg_samples;
        delta_lim <= i_cfg_delta;
        focus_lim <= i_cfg_focus;
        if (i_cfg_mode inside {`TCF_MODE_STREAM, `TCF_MODE_TOUCHDOWN, `TCF_MODE_LIFTOFF})
          mode <= i_cfg_mode;
      end
      if (run && i_rx_valid && i_rx_byte == `TCF_CMD_TOGGLE_SPD) begin
        o_self_pd_en <= !o_self_pd_en;
        o_reply_valid <= 1'b1;
        o_reply_byte <= `TCF_REPLY_ACK;
      end
      if (run && rx_shutdown) begin
        o_reply_valid <= 1'b1;
        o_reply_byte <= `TCF_REPLY_ACK;
      end
    end
  end

  // shift amount for the averaging divide
  always_comb begin
    log2_s = 3'd0;
    for (int k = 0; k < 6; k++) begin
      if (samples[k]) log2_s = 3'(k);
    end
  end

  // oversampling accumulators, one per axis
  generate
    for (genvar a = 0; a < 3; a++) begin : g_acc
      logic [9:0] in_v;
      logic [14:0] sum;
      assign in_v = (a == 0) ? i_sample.x : (a == 1) ? i_sample.y : i_sample.z;
      assign sum = acc[a] + {5'h00, in_v};
      always_ff @(posedge i_clk_sys) begin
        // cleared on lift as well, so a partial sum never leaks into the next touch
        if (rst || !run || !i_touch) begin
          acc[a] <= '0;
          avg[a] <= '0;
        end else if (i_sample_valid && i_touch) begin
          if (acc_n + 6'h01 == samples[5:0]) begin
            acc[a] <= '0;
            avg[a] <= 10'(sum >> log2_s);
          end else begin
            acc[a] <= sum;
          end
        end
      end
    end
  endgenerate

  // sample counter and average strobe
  always_ff @(posedge i_clk_sys) begin
    if (rst || !run || !i_touch) begin
      acc_n <= '0;
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= 1'b0;
      if (i_sample_valid) begin
        if (acc_n + 6'h01 == samples[5:0]) begin
          acc_n <= '0;
          avg_valid <= 1'b1;
        end else begin
          acc_n <= acc_n + 6'h01;
        end
      end
    end
  end

  // delta prediction test, accepted only if both axes fit
  always_comb begin
    accept = 1'b1;
    for (int a = 0; a < 2; a++) begin
      logic signed [12:0] pred;
      logic signed [12:0] dev;
      pred = 13'(2 * $signed({3'b000, hist1[a]})) - $signed({3'b000, hist2[a]});
      dev = $signed({3'b000, avg[a]}) - pred;
      if (dev < 0) dev = -dev;
      if (hist_cnt == 2'd2 && dev > $signed({7'h00, delta_lim})) accept = 1'b0;
    end
  end

  // per axis history and focus filter
  generate
    for (genvar a = 0; a < 2; a++) begin : g_axis
      logic [9:0] diff;
      assign diff = (avg[a] > focus_st[a]) ? avg[a] - focus_st[a] : focus_st[a] - avg[a];
      always_ff @(posedge i_clk_sys) begin
        if (rst || !run || (touch_q && !i_touch)) begin
          hist1[a] <= '0;
          hist2[a] <= '0;
          focus_st[a] <= '0;
          filt[a] <= '0;
        end else if (avg_valid) begin
          hist2[a] <= hist1[a];
          hist1[a] <= avg[a];
          if (accept) begin
            if (focus_lim == 6'h00 || !first_sent || diff >= {4'h0, focus_lim}) begin
              focus_st[a] <= avg[a];
              filt[a] <= avg[a];
            end else begin
              filt[a] <= focus_st[a];
            end
          end
        end
      end
    end
  endgenerate

  // filter output strobe and history depth
  always_ff @(posedge i_clk_sys) begin
    if (rst || !run || (touch_q && !i_touch)) begin
      filt_valid <= 1'b0;
      filt_z <= '0;
      hist_cnt <= '0;
      first_sent <= 1'b0;
    end else begin
      filt_valid <= avg_valid && accept;
      if (avg_valid && hist_cnt != 2'd2) hist_cnt <= hist_cnt + 2'd1;
      if (avg_valid && accept) begin
        filt_z <= avg[2];
        first_sent <= 1'b1;
      end
    end
  end

  // reporting mode selects what enters the transmit fifo
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      touch_q <= 1'b0;
      have_last <= 1'b0;
      last_coord <= '0;
    end else begin
      touch_q <= i_touch && run;
      if (filt_valid) begin
        last_coord <= '{x: filt[0], y: filt[1], z: filt_z};
        have_last <= 1'b1;
      end else if (!i_touch || !run) begin
        have_last <= 1'b0;
      end
    end
  end

  // fifo entry; touchdown sends only the first filtered coordinate
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = '{x: filt[0], y: filt[1], z: filt_z};
    if (run) begin
      if (mode == `TCF_MODE_STREAM) fifo_in_valid = filt_valid;
      else if (mode == `TCF_MODE_TOUCHDOWN) fifo_in_valid = filt_valid && !have_last;
      else if (touch_q && !i_touch && have_last) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = last_coord;
      end
    end
  end

  tcf_fifo #(
    .WIDTH($bits(tcf_pkg::tcf_coord_type)),
    .DEPTH(`TCF_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(rst),
    .i_flush(o_uart_flush),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_tx_ready && !o_tx_valid && run),
    .o_out_data(fifo_out_data)
  );

  // transmit register; drops a new coordinate when the fifo is full
  always_ff @(posedge i_clk_sys) begin
    if (rst || o_uart_flush) begin
      o_tx_valid <= 1'b0;
      o_tx_coord <= '0;
    end else if (o_tx_valid) begin
      if (i_tx_ready) o_tx_valid <= 1'b0;
    end else if (fifo_out_valid && i_tx_ready && run) begin
      o_tx_valid <= 1'b1;
      o_tx_coord <= fifo_out_data;
    end
  end

  a_indicator_stby: assert property (@(posedge i_clk_sys) disable iff (rst)
    !i_standby_force_n |=> o_activity_indicator) else $error("indicator low in standby");
  a_shutdown_ack: assert property (@(posedge i_clk_sys) disable iff (rst)
    run && rx_shutdown |=> o_reply_valid && o_reply_byte == `TCF_REPLY_ACK) else $error("no ack");
  a_shutdown_sleep: assert property (@(posedge i_clk_sys) disable iff (rst)
    run && rx_shutdown |=> pwr == tcf_pkg::TCF_SLEEP_CMD) else $error("no sleep");
  a_force_hold: assert property (@(posedge i_clk_sys) disable iff (rst)
    !i_standby_force_n |=> $stable(pwr)) else $error("state moved under force");
  a_force_flush: assert property (@(posedge i_clk_sys) disable iff (rst)
    $rose(i_standby_force_n) |=> o_uart_flush) else $error("no flush on release");
  a_cmd_wake: assert property (@(posedge i_clk_sys) disable iff (rst)
    pwr == tcf_pkg::TCF_SLEEP_CMD && !o_self_pd_en && !rx_wakeup && i_standby_force_n
    |=> pwr == tcf_pkg::TCF_SLEEP_CMD) else $error("woke without wakeup");
  a_self_wake: assert property (@(posedge i_clk_sys) disable iff (rst)
    pwr == tcf_pkg::TCF_SLEEP_SELF && i_touch && i_standby_force_n |=> pwr == tcf_pkg::TCF_RUN)
    else $error("no wake on touch");
  a_stream_out: assert property (@(posedge i_clk_sys) disable iff (rst)
    run && mode == `TCF_MODE_STREAM && filt_valid && fifo_in_ready |-> fifo_in_valid)
    else $error("stream lost coord");
endmodule : tcf_core

// [src/tcf_consts.svh]
// constants for the touch coordinate filter and power block
`ifndef TCF_CONSTS_SVH
`define TCF_CONSTS_SVH
`define TCF_CMD_TOGGLE_SPD 8'ha2
`define TCF_CMD_WAKEUP 8'ha7
`define TCF_CMD_SHUTDOWN 8'ha8
`define TCF_REPLY_ACK 8'hca
`define TCF_MODE_STREAM 8'h01
`define TCF_MODE_TOUCHDOWN 8'h02
`define TCF_MODE_LIFTOFF 8'h04
`define TCF_SAMPLES_DEFAULT 8'h08
`define TCF_DELTA_DEFAULT 6'h08
`define TCF_FOCUS_DEFAULT 6'h04
`define TCF_SPD_DEFAULT 1'b1
`define TCF_IDLE_TIMEOUT_CYCLES 16'hffff
`define TCF_FIFO_DEPTH 16
`endif

// [src/tcf_pkg.sv]
// types for the touch coordinate filter and power block
package tcf_pkg;
  typedef struct packed {
    logic [9:0] x;
    logic [9:0] y;
    logic [9:0] z;
  } tcf_coord_type;
  typedef enum logic [2:0] {
    TCF_RUN = 3'b001,
    TCF_SLEEP_SELF = 3'b010,
    TCF_SLEEP_CMD = 3'b100
  } tcf_pwr_type;
endpackage : tcf_pkg

// [src/tcf_fifo.sv]
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tcf_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  // storage write
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
  // pointers and occupancy; flush empties at once
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tcf_fifo

// [dv/tcf_host.sv]
// host driver model: sends uart bytes, takes coordinates with optional stalls
`timescale 1ns/1ps
module tcf_host #(
  parameter int WAKE_GAP = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_tx_valid,
  input wire tcf_pkg::tcf_coord_type i_tx_coord,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte
);
  tcf_pkg::tcf_coord_type got_q[$];
  logic slow = 1'b0;
  logic stall = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end
  // slow mode drops ready every other cycle so the fifo sees back pressure
  always @(posedge i_clk_sys) begin
    if (i_tx_valid && o_tx_ready) got_q.push_back(i_tx_coord);
    stall <= #1 slow && !stall;
  end
  assign o_tx_ready = !stall;
  // one byte per call, held over exactly one taking edge
  task automatic send_byte(input logic [7:0] b);
    @(posedge i_clk_sys);
    #1;
    o_rx_valid = 1'b1;
    o_rx_byte = b;
    @(posedge i_clk_sys);
    #1;
    o_rx_valid = 1'b0;
    o_rx_byte = ~b; // released line must not keep the old byte
  endtask : send_byte
  // quiet time after a wakeup byte, shortened for simulation
  task automatic gap();
    repeat (WAKE_GAP) @(posedge i_clk_sys);
  endtask : gap
endmodule : tcf_host

// [dv/touch_coordinate_filter_power_test.sv]
// self-checking bench for the coordinate filter and standby core
`timescale 1ns/1ps
`include "tcf_consts.svh"
module touch_coordinate_filter_power_test;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_brownout = 1'b0;
  logic i_touch = 1'b0;
  logic i_sample_valid = 1'b0;
  tcf_pkg::tcf_coord_type i_sample = '0;
  logic i_standby_force_n = 1'b1;
  logic i_cfg_we = 1'b0;
  logic [7:0] i_cfg_samples = 8'h08;
  logic [5:0] i_cfg_delta = 6'h08;
  logic [5:0] i_cfg_focus = 6'h04;
  logic [7:0] i_cfg_mode = 8'h01;
  logic rx_valid, tx_ready, o_tx_valid, o_reply_valid, o_uart_flush;
  logic o_standby, o_activity_indicator, o_self_pd_en, flush_seen;
  logic [7:0] rx_byte, o_reply_byte;
  tcf_pkg::tcf_coord_type o_tx_coord;
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  tcf_core i_tcf_core (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_brownout(i_brownout),
    .i_touch(i_touch), .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .i_standby_force_n(i_standby_force_n), .i_cfg_we(i_cfg_we),
    .i_cfg_samples(i_cfg_samples), .i_cfg_delta(i_cfg_delta), .i_cfg_focus(i_cfg_focus),
    .i_cfg_mode(i_cfg_mode), .i_tx_ready(tx_ready), .o_tx_valid(o_tx_valid), .o_tx_coord(o_tx_coord),
    .o_reply_valid(o_reply_valid), .o_reply_byte(o_reply_byte), .o_uart_flush(o_uart_flush),
    .o_standby(o_standby), .o_activity_indicator(o_activity_indicator), .o_self_pd_en(o_self_pd_en));
  tcf_host i_tcf_host (.i_clk_sys(i_clk_sys), .i_tx_valid(o_tx_valid), .i_tx_coord(o_tx_coord),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic smp(input logic [9:0] x, input logic [9:0] y);
    tick(1);
    i_sample_valid = 1'b1;
    i_sample = {x, y, 10'h007};
    tick(1);
    i_sample_valid = 1'b0;
  endtask : smp
  task automatic cfg(input logic [7:0] s, input logic [5:0] d, input logic [5:0] f, input logic [7:0] m);
    tick(1);
    i_cfg_we = 1'b1;
    {i_cfg_samples, i_cfg_delta, i_cfg_focus, i_cfg_mode} = {s, d, f, m};
    tick(1);
    i_cfg_we = 1'b0;
    i_tcf_host.got_q.delete();
  endtask : cfg
  // bounded wait for n coordinates, then make sure no extra ones follow
  task automatic expect_q(input int n);
    int k;
    k = 0;
    while (i_tcf_host.got_q.size() < n && k < 300) begin
      tick(1);
      k++;
    end
    tick(20);
    check(i_tcf_host.got_q.size(), n);
  endtask : expect_q
  task automatic got(input int i, input logic [9:0] x, input logic [9:0] y);
    check(i_tcf_host.got_q[i], {2'b00, x, y, 10'h007});
  endtask : got
  task automatic lift();
    tick(1);
    i_touch = 1'b0;
    tick(5);
  endtask : lift
  // returns just after the taking edge, while the one-cycle reply and flush pulses still stand
  task automatic cmd(input logic [7:0] b);
    i_tcf_host.send_byte(b);
  endtask : cmd
  // watch a few cycles for the wake, noting the flush pulse on the way
  task automatic wait_wake();
    flush_seen = 1'b0;
    for (int k = 0; k < 4 && o_standby !== 1'b0; k++) begin
      tick(1);
      flush_seen = flush_seen | o_uart_flush;
    end
  endtask : wait_wake
  // scenarios
  task automatic s_reset();
    check({o_standby, o_activity_indicator, o_self_pd_en, o_tx_valid, o_reply_valid}, 5'b00100);
    cmd(`TCF_CMD_TOGGLE_SPD);
    tick(1);
    check(o_self_pd_en, 1'b0);
    i_brownout = 1'b1;
    tick(1);
    i_brownout = 1'b0;
    tick(1);
    check(o_self_pd_en, 1'b1);
  endtask : s_reset
  task automatic s_defaults();
    i_tcf_host.got_q.delete();
    i_touch = 1'b1;
    for (int k = 0; k < 8; k++) smp(10'(10 + k), 10'd100);
    for (int k = 0; k < 8; k++) smp(10'd20, 10'd100);
    expect_q(2);
    got(0, 10'd13, 10'd100);
    got(1, 10'd20, 10'd100);
    lift();
  endtask : s_defaults
  task automatic s_delta();
    cfg(8'h01, 6'h08, 6'h00, `TCF_MODE_STREAM);
    i_touch = 1'b1;
    smp(10'd100, 10'd300);
    smp(10'd104, 10'd290);
    smp(10'd200, 10'd280);
    smp(10'd296, 10'd270);
    smp(10'd400, 10'd260);
    expect_q(4);
    got(1, 10'd104, 10'd290);
    got(2, 10'd296, 10'd270);
    got(3, 10'd400, 10'd260);
    lift();
  endtask : s_delta
  task automatic s_focus();
    cfg(8'h01, 6'h3f, 6'h04, `TCF_MODE_STREAM);
    i_tcf_host.slow = 1'b1;
    i_touch = 1'b1;
    smp(10'd100, 10'd50);
    smp(10'd102, 10'd50);
    smp(10'd104, 10'd50);
    smp(10'd105, 10'd50);
    expect_q(4);
    got(1, 10'd100, 10'd50);
    got(2, 10'd104, 10'd50);
    got(3, 10'd104, 10'd50);
    i_tcf_host.slow = 1'b0;
    lift();
  endtask : s_focus
  task automatic s_modes();
    cfg(8'h01, 6'h3f, 6'h00, `TCF_MODE_TOUCHDOWN);
    i_touch = 1'b1;
    smp(10'd10, 10'd20);
    smp(10'd30, 10'd40);
    smp(10'd50, 10'd60);
    expect_q(1);
    got(0, 10'd10, 10'd20);
    lift();
    cfg(8'h01, 6'h3f, 6'h00, `TCF_MODE_LIFTOFF);
    i_touch = 1'b1;
    smp(10'd10, 10'd20);
    smp(10'd30, 10'd40);
    smp(10'd50, 10'd60);
    tick(20);
    check(i_tcf_host.got_q.size(), 0);
    lift();
    expect_q(1);
    got(0, 10'd50, 10'd60);
    cfg(8'h01, 6'h3f, 6'h00, `TCF_MODE_STREAM);
  endtask : s_modes
  task automatic s_shutdown();
    cmd(`TCF_CMD_SHUTDOWN);
    check({o_reply_valid, o_reply_byte}, {1'b1, `TCF_REPLY_ACK});
    check({o_standby, o_activity_indicator}, 2'b11);
    i_touch = 1'b1;
    wait_wake();
    check({flush_seen, o_standby}, 2'b10);
    lift();
  endtask : s_shutdown
  task automatic s_toggle();
    cmd(`TCF_CMD_TOGGLE_SPD);
    check({o_reply_valid, o_reply_byte, o_self_pd_en}, {1'b1, `TCF_REPLY_ACK, 1'b0});
    cmd(`TCF_CMD_SHUTDOWN);
    i_touch = 1'b1;
    tick(6);
    check(o_standby, 1'b1);
    lift();
    cmd(`TCF_CMD_WAKEUP);
    check({o_reply_valid, o_uart_flush, o_standby}, 3'b010);
    i_tcf_host.gap();
    cmd(`TCF_CMD_TOGGLE_SPD);
    tick(1);
    check(o_self_pd_en, 1'b1);
  endtask : s_toggle
  task automatic s_force();
    i_tcf_host.got_q.delete();
    i_standby_force_n = 1'b0;
    tick(2);
    check({o_standby, o_activity_indicator}, 2'b11);
    cmd(`TCF_CMD_TOGGLE_SPD);
    check({o_reply_valid, o_self_pd_en}, 2'b01);
    i_touch = 1'b1;
    smp(10'd5, 10'd5);
    tick(6);
    check({o_standby, i_tcf_host.got_q.size() == 0}, 2'b11);
    lift();
    i_standby_force_n = 1'b1;
    wait_wake();
    check({flush_seen, o_standby}, 2'b10);
  endtask : s_force
  task automatic s_idle();
    for (int k = 0; k < 70000 && o_standby !== 1'b1; k++) tick(1);
    check({o_standby, o_activity_indicator}, 2'b11);
    i_touch = 1'b1;
    tick(4);
    check(o_standby, 1'b0);
    lift();
  endtask : s_idle
  // single exit point for pass, fail and timeout
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // idle wait dominates (about 66k cycles), so the limit sits above it but under 100k cycles
  initial begin
    #450us;
    n_errors++;
    wrap_up();
  end
  initial begin
    tick(2);
    i_reset = 1'b0;
    s_reset();
    s_defaults();
    s_delta();
    s_focus();
    s_modes();
    s_shutdown();
    s_toggle();
    s_force();
    s_idle();
    wrap_up();
  end
endmodule : touch_coordinate_filter_power_test
